/* File: include/slr_pkg.sv */
// Purpose: constants and carriers for the sync line rate and cts delay block
// Assumes: 100 MHz system clock, static jumper selectors
// Notes: selector codes are binary, rate codes 0 to 5 and delay codes 0 to 2
// Behaviour
// - six selectable rates, 600 to 19200 bps
// - factory rate setting gives 9600 bps
// - bit clock generated internally, driven out
// - wait configured delay after rts before cts
// - delay choices long 53, short 7, none
// - factory delay setting gives immediate cts
// - transmit and receive pairs run simultaneously
// - control signals never cross the line
package slr_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RATE_N = 6;
  localparam logic [2:0] RATE_600   = 3'h0;
  localparam logic [2:0] RATE_1200  = 3'h1;
  localparam logic [2:0] RATE_2400  = 3'h2;
  localparam logic [2:0] RATE_4800  = 3'h3;
  localparam logic [2:0] RATE_9600  = 3'h4;
  localparam logic [2:0] RATE_19200 = 3'h5;
  localparam logic [2:0] RATE_DEFAULT = RATE_9600;
  localparam logic [1:0] DLY_NONE  = 2'h0;
  localparam logic [1:0] DLY_SHORT = 2'h1;
  localparam logic [1:0] DLY_LONG  = 2'h2;
  localparam logic [1:0] DLY_DEFAULT = DLY_NONE;
  localparam int unsigned DLY_LONG_MS  = 53;
  localparam int unsigned DLY_SHORT_MS = 7;
  localparam int unsigned DLY_LONG_CYC  = DLY_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned DLY_SHORT_CYC = DLY_SHORT_MS * (CLK_HZ / 1000);
  // half period cycles: 100e6/(2*bps), truncated, error well under 0.01 percent
  localparam int unsigned HALF_600   = CLK_HZ / (2 * 600);
  localparam int unsigned HALF_19200 = CLK_HZ / (2 * 19200);
  localparam int unsigned SYNC_W = 3;
  typedef struct packed {
    logic [SYNC_W-1:0] rts_sync;
    logic [SYNC_W-1:0] td_sync;
    logic [SYNC_W-1:0] line_rx_sync;
    logic              rts;
    logic [22:0]       dly_cnt;
    logic              cts;
    logic [16:0]       div_cnt;
    logic              bit_clk;
    logic              tx_bit;
    logic              rd_bit;
  } slr_state_s;
endpackage : slr_pkg

/* File: rtl/slr_core.sv */
// Purpose: rate clock generator, cts delay and full duplex data path
// Assumes: selectors static; td sampled and rd updated on the rising bit clock
// Notes: control lines stay local and never reach the line pair
module slr_core #(
  parameter int unsigned LONG_CYC  = slr_pkg::DLY_LONG_CYC,
  parameter int unsigned SHORT_CYC = slr_pkg::DLY_SHORT_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic [2:0] i_rate_sel,
  input  wire logic [1:0] i_dly_sel,
  input  wire logic       i_rts,
  input  wire logic       i_td,
  input  wire logic       i_line_rx,
  output logic            o_cts,
  output logic            o_tx_clk,
  output logic            o_rx_clk,
  output logic            o_line_tx,
  output logic            o_rd
);

  localparam int unsigned DIV_W = 17;
  localparam int unsigned DLY_W = 23;

  // delay counter must reach the longest target
  if (LONG_CYC < 2 || SHORT_CYC < 2)
  begin : g_dly_min
    $error("slr_core: delay counts too small");
  end

  if (LONG_CYC >= (1 << DLY_W) || SHORT_CYC >= (1 << DLY_W))
  begin : g_dly_max
    $error("slr_core: delay counts exceed counter");
  end

  // slowest rate sets the divider width
  if (slr_pkg::HALF_600 >= (1 << DIV_W))
  begin : g_div_max
    $error("slr_core: divider too narrow for slowest rate");
  end

  slr_pkg::slr_state_s st_reg;
  slr_pkg::slr_state_s st_next;

  logic [DIV_W-1:0] half;
  logic [DLY_W-1:0] dly_tgt;
  logic             rts_hi;
  logic             rts_lo;
  logic             td_agree;
  logic             rx_agree;
  logic             div_wrap;
  logic             rise;

  always_comb
  begin
    unique case (i_rate_sel)
      slr_pkg::RATE_600:
      begin
        half = DIV_W'(slr_pkg::HALF_600);
      end
      slr_pkg::RATE_1200:
      begin
        half = DIV_W'(slr_pkg::HALF_600 / 2);
      end
      slr_pkg::RATE_2400:
      begin
        half = DIV_W'(slr_pkg::HALF_600 / 4);
      end
      slr_pkg::RATE_4800:
      begin
        half = DIV_W'(slr_pkg::HALF_600 / 8);
      end
      slr_pkg::RATE_19200:
      begin
        half = DIV_W'(slr_pkg::HALF_19200);
      end
      default:
      begin
        half = DIV_W'(slr_pkg::HALF_600 / 16);
      end
    endcase
  end

  always_comb
  begin
    unique case (i_dly_sel)
      slr_pkg::DLY_LONG:
      begin
        dly_tgt = DLY_W'(LONG_CYC);
      end
      slr_pkg::DLY_SHORT:
      begin
        dly_tgt = DLY_W'(SHORT_CYC);
      end
      default:
      begin
        dly_tgt = 23'h00_0000;
      end
    endcase
  end

  // level seen once stages two and three agree
  always_comb
  begin
    rts_hi   = st_reg.rts_sync[2] & st_reg.rts_sync[1];
    rts_lo   = ~st_reg.rts_sync[2] & ~st_reg.rts_sync[1];
    td_agree = (st_reg.td_sync[2] == st_reg.td_sync[1]);
    rx_agree = (st_reg.line_rx_sync[2] == st_reg.line_rx_sync[1]);
  end

  always_comb
  begin
    div_wrap = (st_reg.div_cnt >= half - 17'h0_0001);
    rise     = div_wrap & ~st_reg.bit_clk;
  end

  always_comb
  begin
    st_next = st_reg;

    // three stage synchronisers
    st_next.rts_sync     = {st_reg.rts_sync[1:0], i_rts};
    st_next.td_sync      = {st_reg.td_sync[1:0], i_td};
    st_next.line_rx_sync = {st_reg.line_rx_sync[1:0], i_line_rx};

    // glitches under two cycles never move the level
    if (rts_hi)
    begin
      st_next.rts = 1'b1;
    end
    else if (rts_lo)
    begin
      st_next.rts = 1'b0;
    end

    if (!st_reg.rts)
    begin
      st_next.cts     = 1'b0;
      st_next.dly_cnt = 23'h00_0000;
    end
    else if (!st_reg.cts)
    begin
      if (st_reg.dly_cnt >= dly_tgt)
      begin
        st_next.cts = 1'b1;
      end
      else
      begin
        st_next.dly_cnt = st_reg.dly_cnt + 23'h00_0001;
      end
    end

    if (div_wrap)
    begin
      st_next.div_cnt = 17'h0_0000;
      st_next.bit_clk = ~st_reg.bit_clk;
    end
    else
    begin
      st_next.div_cnt = st_reg.div_cnt + 17'h0_0001;
    end

    // both directions move each bit
    // a bit still settling keeps the previous level
    if (rise)
    begin
      if (td_agree)
      begin
        st_next.tx_bit = st_reg.td_sync[2];
      end
      if (rx_agree)
      begin
        st_next.rd_bit = st_reg.line_rx_sync[2];
      end
    end
  end

  // data idles at mark level during reset
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st_reg         <= '0;
      st_reg.tx_bit  <= 1'b1;
      st_reg.rd_bit  <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // cts local only, line carries data
  assign o_cts     = st_reg.cts;
  assign o_tx_clk  = st_reg.bit_clk;
  assign o_rx_clk  = st_reg.bit_clk;
  assign o_line_tx = st_reg.tx_bit;
  assign o_rd      = st_reg.rd_bit;

endmodule : slr_core

/* File: verif/slr_chk.sv */
// Purpose: port checks for slr_core
// Assumes: selectors static between resets
// Notes: margins cover sync stages
module slr_chk #(
  parameter int unsigned LONG_CYC  = 50,
  parameter int unsigned SHORT_CYC = 10
) (
  input wire logic       i_clk, i_srst, i_rts, i_td, i_line_rx,
  input wire logic [2:0] i_rate_sel,
  input wire logic [1:0] i_dly_sel,
  input wire logic       o_cts, o_tx_clk, o_rx_clk, o_line_tx, o_rd
);
  int   hi, ph;
  logic lc, sn;
  always_ff @(posedge i_clk)
    hi <= (i_srst || !i_rts) ? 0 : hi + 1;
  always_ff @(posedge i_clk)
    lc <= o_tx_clk;
  // first toggle after reset is counted from reset, one cycle over a half period
  always_ff @(posedge i_clk)
    sn <= i_srst ? 1'b0 : (sn | (o_tx_clk != lc));
  always_ff @(posedge i_clk)
    ph <= (i_srst || o_tx_clk != lc) ? 1 : ph + 1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  same_clk_a: assert property (o_tx_clk == o_rx_clk) else $error("clocks differ");
  half_per_a: assert property (sn && o_tx_clk != lc && i_rate_sel < 3'h6
    |-> ph == slr_pkg::CLK_HZ / (1200 << i_rate_sel)) else $error("bit clock period");
  cts_none_a: assert property ((i_dly_sel == slr_pkg::DLY_NONE && i_rts)[*8]
    |-> o_cts) else $error("cts late");
  cts_drop_a: assert property ((!i_rts)[*8] |-> !o_cts) else $error("cts stuck");
  short_late_a: assert property (hi > SHORT_CYC + 8 && i_dly_sel == slr_pkg::DLY_SHORT
    |-> o_cts) else $error("short late");
  short_early_a: assert property ($rose(o_cts) && i_dly_sel == slr_pkg::DLY_SHORT
    |-> hi >= SHORT_CYC + 3) else $error("short early");
  long_early_a: assert property ($rose(o_cts) && i_dly_sel == slr_pkg::DLY_LONG
    |-> hi >= LONG_CYC + 3) else $error("long early");
  data_edge_a: assert property ($changed(o_line_tx) || $changed(o_rd) |-> o_tx_clk)
    else $error("data off edge");
endmodule : slr_chk
bind slr_core slr_chk #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) u_chk (.*);

/* File: verif/slr_dte.sv */
// Purpose: attached terminal model
// Assumes: unit supplies the bit clock
// Notes: bit value set by the bench
module slr_dte (
  input  wire logic i_clk,
  input  wire logic i_bc,
  input  wire logic i_rd,
  input  wire logic i_bit,
  output logic      o_td,
  output logic      o_rx
);
  logic bq = 1'b0;
  initial o_td = 1'b1;
  always @(negedge i_clk)
  begin
    bq <= i_bc;
    if (bq && !i_bc)
      o_td <= i_bit;
    if (!bq && i_bc)
      o_rx <= i_rd;
  end
endmodule : slr_dte

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for slr_core
// Assumes: line looped back, same rate both ends
// Notes: short delays via parameters
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, rts = 0, bit_v = 1, cts, tc, rc, ltx, rd, td, rx;
  logic [2:0] rate = slr_pkg::RATE_DEFAULT;
  logic [1:0] dly = slr_pkg::DLY_DEFAULT;
  int num_errors = 0, n_compared = 0, cyc = 0, n;
  // looped line means both ends share one rate
  slr_core #(.LONG_CYC(50), .SHORT_CYC(10)) u_dut (.i_clk(clk), .i_srst(rst), .i_rate_sel(rate),
    .i_dly_sel(dly), .i_rts(rts), .i_td(td), .i_line_rx(ltx), .o_cts(cts), .o_tx_clk(tc),
    .o_rx_clk(rc), .o_line_tx(ltx), .o_rd(rd));
  slr_dte u_dte (.i_clk(clk), .i_bc(tc), .i_rd(rd), .i_bit(bit_v), .o_td(td), .o_rx(rx));
  initial forever #5 clk = ~clk;
  task automatic summarize();
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  always @(posedge clk)
    if (++cyc == 80000)
    begin
      num_errors++;
      summarize();
    end
  task automatic rst_to(input logic [2:0] r, input logic [1:0] d);
    @(negedge clk);
    {rate, dly, rst} = {r, d, 1'b1};
    repeat (20) @(negedge clk);
    rst = 0;
  endtask : rst_to
  task automatic t_cts(input logic [1:0] d, input int w);
    rst_to(slr_pkg::RATE_DEFAULT, d);
    rts = 1;
    @(negedge clk);
    rts = 0;
    repeat (12) @(negedge clk);
    chk(cts === 1'b0, "runt gave cts");
    repeat (2)
    begin
      rts = 1;
      for (n = 0; cts !== 1'b1 && n < 200; n++) @(negedge clk);
      chk(n >= w + 3 && n <= w + 7, "cts delay");
      rts = 0;
      repeat (8) @(negedge clk);
      chk(cts === 1'b0, "cts held");
    end
  endtask : t_cts
  task automatic t_clk(input logic [2:0] r);
    rst_to(r, slr_pkg::DLY_DEFAULT);
    @(posedge tc);
    n = cyc;
    @(posedge tc);
    chk(cyc - n == 2 * slr_pkg::CLK_HZ / (1200 << r), "bit period");
  endtask : t_clk
  task automatic t_data(input logic v);
    bit_v = v;
    repeat (3) @(posedge tc);
    repeat (2) @(negedge clk);
    chk(ltx === v && rx === v, "line data");
  endtask : t_data
  initial
  begin
    t_cts(slr_pkg::DLY_NONE, 0);
    t_cts(slr_pkg::DLY_SHORT, 10);
    t_cts(slr_pkg::DLY_LONG, 50);
    t_clk(slr_pkg::RATE_9600);
    t_clk(slr_pkg::RATE_19200);
    t_data(1'b0);
    t_data(1'b1);
    summarize();
  end
endmodule : tb_top
